// >>> core/dual_dac_pkg.sv
package dual_dac_pkg;
  // word layout
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 12;
  localparam int CODE_MSB = 11;
  localparam logic [4:0] FULL_COUNT = 5'h10;
  localparam logic [4:0] COUNT_LIMIT = 5'h11;
  localparam logic [4:0] COUNT_ONE = 5'h01;

  // command codes on the four control bits
  localparam logic [3:0] CMD_STORE_A = 4'h0;
  localparam logic [3:0] CMD_STORE_B = 4'h2;
  localparam logic [3:0] CMD_UPDATE_A = 4'h4;
  localparam logic [3:0] CMD_UPDATE_A_COPY_B = 4'h6;
  localparam logic [3:0] CMD_UPDATE_B = 4'h8;
  localparam logic [3:0] CMD_UPDATE_B_COPY_A = 4'ha;
  localparam logic [3:0] CMD_UPDATE_ALL = 4'hc;
  localparam logic [3:0] CMD_COPY_ALL = 4'he;

  // codes
  localparam logic [11:0] ZERO_CODE = 12'h000;
  localparam logic [11:0] SIGN_FLIP = 12'h800;
  localparam logic [11:0] MIDSCALE_LEVEL = 12'h800;

  // apb map
  localparam int ADDR_BITS = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] LAST_WORD_OFFSET = 8'h08;
  localparam logic [7:0] OUT_A_OFFSET = 8'h0c;
  localparam logic [7:0] OUT_B_OFFSET = 8'h10;
  localparam logic [7:0] STAGE_A_OFFSET = 8'h14;
  localparam logic [7:0] STAGE_B_OFFSET = 8'h18;
  localparam logic [7:0] FRAME_COUNT_OFFSET = 8'h1c;

  // fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int STATUS_SHORT_BIT = 0;
  localparam int STATUS_IGNORED_BIT = 1;
  localparam int STATUS_CLEAR_BIT = 2;
  localparam int STATUS_CHAIN_BIT = 3;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [15:0] FRAME_COUNT_RESET = 16'h0000;
  localparam logic [15:0] FRAME_COUNT_STEP = 16'h0001;
endpackage

// >>> core/channel_if.sv
`timescale 1ns/100ps
interface channel_if;
  logic load_stage;
  logic load_out;
  logic copy_stage;
  logic [11:0] data;
  logic [11:0] stage;
  logic [11:0] out_code;
  logic [11:0] tap_level;

  modport ctl (
    output load_stage,
    output load_out,
    output copy_stage,
    output data,
    input stage,
    input out_code,
    input tap_level
  );
  modport chan (
    input load_stage,
    input load_out,
    input copy_stage,
    input data,
    output stage,
    output out_code,
    output tap_level
  );
endinterface

// >>> core/dac_channel.sv
`timescale 1ns/100ps
module dac_channel (
  // clock and clear
  input wire logic pclk,
  input wire logic clear_n,
  // decoder side
  channel_if.chan ch
);
  logic [11:0] stage_reg;
  logic [11:0] out_reg;
  logic [11:0] tap_reg;
  logic [11:0] out_next;

  assign out_next = ch.load_out ? ch.data : (ch.copy_stage ? stage_reg : out_reg);

  always_ff @(posedge pclk or negedge clear_n) begin
    if (!clear_n) begin
      stage_reg <= dual_dac_pkg::ZERO_CODE;
      out_reg <= dual_dac_pkg::ZERO_CODE;
      tap_reg <= dual_dac_pkg::MIDSCALE_LEVEL;
    end else begin
      if (ch.load_stage) begin
        stage_reg <= ch.data;
      end
      out_reg <= out_next;
      tap_reg <= out_next ^ dual_dac_pkg::SIGN_FLIP;
    end
  end

  assign ch.stage = stage_reg;
  assign ch.out_code = out_reg;
  assign ch.tap_level = tap_reg;
endmodule

// >>> core/dual_dac_serial_command_decoder.sv
// What this block does
// - frame sync falling edge opens a word
// - clear low forces outputs to zero code
// - clear acts without waiting for edges
// - code 0000 stores data in staging A
// - code 0010 stores data in staging B
// - code 0100 updates channel A fully
// - code 0110 updates A, copies B staging
// - codes 1000/1010 update B, 1010 copies A
// - code 1100 updates both channels with data
// - code 1110 copies both stagings, data ignored
// - sixteen bits, msb first, four control bits
// - code is two's complement around midscale
// - after clear, update on next sync rise
`timescale 1ns/100ps
module dual_dac_serial_command_decoder (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  input wire logic serial_clk,
  input wire logic frame_sync_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  // pins
  input wire logic chain_enable,
  input wire logic async_clear_n,
  // converter codes
  output logic [11:0] out_code_a,
  output logic [11:0] out_code_b,
  output logic [11:0] tap_level_a,
  output logic [11:0] tap_level_b
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FRAME = 3'b010,
    ST_EXEC = 3'b100
  } frame_state_t;

  // ---------------- link domain ----------------
  logic [15:0] shift_reg;
  logic [4:0] count_reg;
  logic start_pending_reg;
  logic sdo_reg;
  logic chain_l1_reg;
  logic chain_l2_reg;
  logic [4:0] count_inc;

  // held high by the sync pin between frames, so the next word restarts the count
  always_ff @(negedge serial_clk or posedge frame_sync_n or negedge presetn) begin
    if (!presetn) begin
      start_pending_reg <= 1'b1;
    end else if (frame_sync_n) begin
      start_pending_reg <= 1'b1;
    end else begin
      start_pending_reg <= 1'b0;
    end
  end

  assign count_inc = (count_reg == dual_dac_pkg::COUNT_LIMIT) ? count_reg :
                     count_reg + dual_dac_pkg::COUNT_ONE;

  always_ff @(negedge serial_clk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
      sdo_reg <= 1'b0;
      chain_l1_reg <= 1'b0;
      chain_l2_reg <= 1'b0;
    end else begin
      chain_l1_reg <= chain_enable;
      chain_l2_reg <= chain_l1_reg;
      // edges with sync high only advance the chain enable stages; shift, count and serial out hold
      if (!frame_sync_n) begin
        shift_reg <= {shift_reg[14:0], serial_data_in};
        count_reg <= start_pending_reg ? dual_dac_pkg::COUNT_ONE : count_inc;
        sdo_reg <= chain_l2_reg & shift_reg[15];
      end
    end
  end

  assign serial_data_out = sdo_reg;

  // ---------------- bus domain ----------------
  logic fs_s1_reg;
  logic fs_s2_reg;
  logic clr_s1_reg;
  logic clr_s2_reg;
  logic chain_s1_reg;
  logic chain_s2_reg;
  frame_state_t state_reg;
  frame_state_t state_next;
  logic [15:0] word_reg;
  logic [15:0] frame_count_reg;
  logic enable_reg;
  logic short_reg;
  logic ignored_reg;
  logic [31:0] rdata_reg;
  logic err_reg;
  logic clear_n;

  // clear is combined into the asynchronous reset of the code registers
  assign clear_n = presetn & async_clear_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_s1_reg <= 1'b1;
      fs_s2_reg <= 1'b1;
      clr_s1_reg <= 1'b1;
      clr_s2_reg <= 1'b1;
      chain_s1_reg <= 1'b0;
      chain_s2_reg <= 1'b0;
    end else begin
      fs_s1_reg <= frame_sync_n;
      fs_s2_reg <= fs_s1_reg;
      clr_s1_reg <= async_clear_n;
      clr_s2_reg <= clr_s1_reg;
      chain_s1_reg <= chain_enable;
      chain_s2_reg <= chain_s1_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (!fs_s2_reg) begin
          state_next = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (fs_s2_reg) begin
          state_next = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // shift word and count are quiet while sync is high, so they are taken as they stand
  wire word_taken = (state_reg == ST_FRAME) && fs_s2_reg;
  wire full_frame = (count_reg == dual_dac_pkg::FULL_COUNT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_reg <= 16'h0000;
    end else if (word_taken && full_frame) begin
      word_reg <= shift_reg;
    end
  end

  reg full_seen_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_seen_reg <= 1'b0;
    end else if (word_taken) begin
      full_seen_reg <= full_frame;
    end
  end

  // execution; clear low blocks it so the first sync rise after release updates
  wire exec_ok = (state_reg == ST_EXEC) && full_seen_reg && enable_reg && clr_s2_reg;
  wire exec_short = (state_reg == ST_EXEC) && !full_seen_reg;
  wire [3:0] cmd = word_reg[dual_dac_pkg::CMD_MSB:dual_dac_pkg::CMD_LSB];
  wire [11:0] code = word_reg[dual_dac_pkg::CODE_MSB:0];

  wire dec_store_a = (cmd == dual_dac_pkg::CMD_STORE_A);
  wire dec_store_b = (cmd == dual_dac_pkg::CMD_STORE_B);
  wire dec_upd_a = (cmd == dual_dac_pkg::CMD_UPDATE_A);
  wire dec_upd_a_cb = (cmd == dual_dac_pkg::CMD_UPDATE_A_COPY_B);
  wire dec_upd_b = (cmd == dual_dac_pkg::CMD_UPDATE_B);
  wire dec_upd_b_ca = (cmd == dual_dac_pkg::CMD_UPDATE_B_COPY_A);
  wire dec_upd_all = (cmd == dual_dac_pkg::CMD_UPDATE_ALL);
  wire dec_copy_all = (cmd == dual_dac_pkg::CMD_COPY_ALL);
  wire dec_known = dec_store_a | dec_store_b | dec_upd_a | dec_upd_a_cb |
                   dec_upd_b | dec_upd_b_ca | dec_upd_all | dec_copy_all;

  wire a_load_out = dec_upd_a | dec_upd_a_cb | dec_upd_all;
  wire b_load_out = dec_upd_b | dec_upd_b_ca | dec_upd_all;

  channel_if ch_a ();
  channel_if ch_b ();

  assign ch_a.load_stage = exec_ok & (dec_store_a | a_load_out);
  assign ch_a.load_out = exec_ok & a_load_out;
  assign ch_a.copy_stage = exec_ok & (dec_upd_b_ca | dec_copy_all);
  assign ch_a.data = code;
  assign ch_b.load_stage = exec_ok & (dec_store_b | b_load_out);
  assign ch_b.load_out = exec_ok & b_load_out;
  assign ch_b.copy_stage = exec_ok & (dec_upd_a_cb | dec_copy_all);
  assign ch_b.data = code;

  dac_channel u_chan_a (
    .pclk(pclk),
    .clear_n(clear_n),
    .ch(ch_a.chan)
  );

  dac_channel u_chan_b (
    .pclk(pclk),
    .clear_n(clear_n),
    .ch(ch_b.chan)
  );

  assign out_code_a = ch_a.out_code;
  assign out_code_b = ch_b.out_code;
  assign tap_level_a = ch_a.tap_level;
  assign tap_level_b = ch_b.tap_level;

  // ---------------- apb slave ----------------
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire sel_ctrl = (paddr == dual_dac_pkg::CTRL_OFFSET);
  wire sel_status = (paddr == dual_dac_pkg::STATUS_OFFSET);
  wire sel_last = (paddr == dual_dac_pkg::LAST_WORD_OFFSET);
  wire sel_out_a = (paddr == dual_dac_pkg::OUT_A_OFFSET);
  wire sel_out_b = (paddr == dual_dac_pkg::OUT_B_OFFSET);
  wire sel_stage_a = (paddr == dual_dac_pkg::STAGE_A_OFFSET);
  wire sel_stage_b = (paddr == dual_dac_pkg::STAGE_B_OFFSET);
  wire sel_count = (paddr == dual_dac_pkg::FRAME_COUNT_OFFSET);
  wire mapped = sel_ctrl | sel_status | sel_last | sel_out_a | sel_out_b |
                sel_stage_a | sel_stage_b | sel_count;
  wire status_w1c = wr & sel_status;
  wire short_clr = status_w1c & pwdata[dual_dac_pkg::STATUS_SHORT_BIT];
  wire ignored_clr = status_w1c & pwdata[dual_dac_pkg::STATUS_IGNORED_BIT];
  wire exec_ignored = exec_ok & ~dec_known;

  wire [31:0] status_word = {28'h0000000, chain_s2_reg, ~clr_s2_reg, ignored_reg, short_reg};
  wire [31:0] rdata_sel =
    sel_ctrl ? {31'h00000000, enable_reg} :
    sel_status ? status_word :
    sel_last ? {16'h0000, word_reg} :
    sel_out_a ? {20'h00000, ch_a.out_code} :
    sel_out_b ? {20'h00000, ch_b.out_code} :
    sel_stage_a ? {20'h00000, ch_a.stage} :
    sel_stage_b ? {20'h00000, ch_b.stage} :
    sel_count ? {16'h0000, frame_count_reg} :
    dual_dac_pkg::RDATA_RESET;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= dual_dac_pkg::CTRL_ENABLE_RESET;
    end else if (wr & sel_ctrl) begin
      enable_reg <= pwdata[dual_dac_pkg::CTRL_ENABLE_BIT];
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_reg <= 1'b0;
      ignored_reg <= 1'b0;
    end else begin
      short_reg <= exec_short | (short_reg & ~short_clr);
      ignored_reg <= exec_ignored | (ignored_reg & ~ignored_clr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_count_reg <= dual_dac_pkg::FRAME_COUNT_RESET;
    end else if (exec_ok) begin
      frame_count_reg <= frame_count_reg + dual_dac_pkg::FRAME_COUNT_STEP;
    end
  end

  // read data and error are taken in setup and stand through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= dual_dac_pkg::RDATA_RESET;
      err_reg <= 1'b0;
    end else if (setup) begin
      rdata_reg <= pwrite ? dual_dac_pkg::RDATA_RESET : rdata_sel;
      err_reg <= ~mapped;
    end
  end

  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign pslverr = access & err_reg;
endmodule

// >>> verification/dual_dac_serial_command_decoder_properties.sv
`timescale 1ns/100ps
module dual_dac_serial_command_decoder_properties (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // serial link
  input wire logic serial_clk,
  input wire logic frame_sync_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  // pins
  input wire logic chain_enable,
  input wire logic async_clear_n,
  // converter codes
  input wire logic [11:0] out_code_a,
  input wire logic [11:0] out_code_b,
  input wire logic [11:0] tap_level_a,
  input wire logic [11:0] tap_level_b
);
  logic [4:0] low_cnt_reg;
  // pclk cycles since the frame sync went low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt_reg <= 5'h00;
    else if (frame_sync_n) low_cnt_reg <= 5'h00;
    else if (low_cnt_reg != 5'h1f) low_cnt_reg <= low_cnt_reg + 5'h01;
  end
  sequence setup_unmapped;
    psel && !penable && paddr > 8'h1c;
  endsequence
  sequence setup_mapped;
    psel && !penable && paddr <= 8'h1c && paddr[1:0] == 2'h0;
  endsequence
  sequence access_phase;
    psel && penable;
  endsequence
  a_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !async_clear_n |-> out_code_a == 12'h000 && out_code_b == 12'h000)
    else $error("outputs not zero while clear is low");
  a_clear_midscale: assert property (@(posedge pclk) disable iff (!presetn)
    !async_clear_n |-> tap_level_a == 12'h800 && tap_level_b == 12'h800)
    else $error("levels not midscale while clear is low");
  a_tap_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    tap_level_a == (out_code_a ^ 12'h800)) else $error("level a does not match code a");
  a_tap_code_b: assert property (@(posedge pclk) disable iff (!presetn)
    tap_level_b == (out_code_b ^ 12'h800)) else $error("level b does not match code b");
  a_quiet_frame: assert property (@(posedge pclk) disable iff (!presetn)
    low_cnt_reg > 5'h08 && async_clear_n && $past(async_clear_n)
    |-> $stable({out_code_a, out_code_b})) else $error("output changed inside a frame");
  a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    setup_unmapped ##1 access_phase |-> pslverr) else $error("no error on unmapped access");
  a_slverr_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    setup_mapped ##1 access_phase |-> !pslverr) else $error("error on mapped access");
  a_err_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    access_phase and pslverr and !pwrite |-> prdata == 32'h0) else $error("error read not 0");
  a_serial_off: assert property (@(negedge serial_clk) disable iff (!presetn)
    !chain_enable [*4] |-> !serial_data_out) else $error("serial out active, chain off");
endmodule

// >>> verification/serial_host_model.sv
`timescale 1ns/100ps
module serial_host_model (
  // link
  output logic serial_clk,
  output logic frame_sync_n,
  output logic serial_data_in,
  // chain
  input wire logic serial_data_out,
  input wire logic chain_enable
);
  logic [15:0] rx = 16'h0000;
  initial begin
    serial_clk = 1'b0;
    frame_sync_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // clock idles low between frames; n falling edges per frame
  task automatic send(input logic [15:0] w, input int n);
    #0.7 frame_sync_n = 1'b0;
    #2;
    for (int i = 15; i > 15 - n; i--) begin
      serial_data_in = w[i];
      #2 serial_clk = 1'b1;
      #3 serial_clk = 1'b0;
      #1 rx = {rx[14:0], serial_data_out};
    end
    frame_sync_n = 1'b1;
    serial_data_in = ~serial_data_in;
    if (chain_enable) begin
      #3 serial_clk = 1'b1;
      #3 serial_clk = 1'b0;
    end
    #25;
  endtask
endmodule

// >>> verification/tb_dual_dac_serial_command_decoder.sv
`timescale 1ns/100ps
bind dual_dac_serial_command_decoder dual_dac_serial_command_decoder_properties u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_clk(serial_clk), .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
  .serial_data_out(serial_data_out), .chain_enable(chain_enable),
  .async_clear_n(async_clear_n), .out_code_a(out_code_a), .out_code_b(out_code_b),
  .tap_level_a(tap_level_a), .tap_level_b(tap_level_b));
module tb_dual_dac_serial_command_decoder;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, serial_clk, frame_sync_n, serial_data_in, serial_data_out;
  logic chain_enable = 1'b0;
  logic async_clear_n = 1'b1;
  logic en = 1'b1;
  logic [11:0] out_code_a, out_code_b, tap_level_a, tap_level_b, d1;
  logic [11:0] sa = 12'h0, sb = 12'h0, oa = 12'h0, ob = 12'h0;
  logic [31:0] q[$];
  logic [3:0] cmds[9] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'he, 4'h1};
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  always #2.5 pclk = ~pclk;
  dual_dac_serial_command_decoder u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clk(serial_clk), .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .chain_enable(chain_enable),
    .async_clear_n(async_clear_n), .out_code_a(out_code_a), .out_code_b(out_code_b),
    .tap_level_a(tap_level_a), .tap_level_b(tap_level_b));
  serial_host_model u_host (
    .serial_clk(serial_clk), .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .chain_enable(chain_enable));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    q.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask
  // read results are compared as they complete
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check(prdata, q.pop_front());
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic frame(input logic [3:0] c, input logic [11:0] d, input int n);
    u_host.send({c, d}, n);
    if (n == 16 && async_clear_n && en) case (c)
      4'h0: sa = d;
      4'h2: sb = d;
      4'h4: {sa, oa} = {d, d};
      4'h6: {sa, oa, ob} = {d, d, sb};
      4'h8: {sb, ob} = {d, d};
      4'ha: {sb, ob, oa} = {d, d, sa};
      4'hc: {sa, sb, oa, ob} = {d, d, d, d};
      4'he: {oa, ob} = {sa, sb};
      default: ;
    endcase
    repeat (8) @(posedge pclk);
    rd(8'h0c, {20'h0, oa});
    rd(8'h10, {20'h0, ob});
    rd(8'h14, {20'h0, sa});
    rd(8'h18, {20'h0, sb});
    check({20'h0, tap_level_b}, {20'h0, ob ^ 12'h800});
    check({20'h0, tap_level_a}, {20'h0, oa ^ 12'h800});
    check({20'h0, out_code_a}, {20'h0, oa});
    check({20'h0, out_code_b}, {20'h0, ob});
  endtask
  initial begin
    void'($urandom(32'hc59a));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h1);
    rd(8'h1c, 32'h0);
    rd(8'h20, 32'h0);
    repeat (2) foreach (cmds[i]) frame(cmds[i], 12'($urandom), 16);
    frame(4'hc, 12'h800, 16);
    frame(4'hc, 12'h7ff, 16);
    frame(4'h4, 12'($urandom), 15);
    rd(8'h04, 32'h3);
    apb(1'b1, 8'h04, 32'h3);
    rd(8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h0);
    en = 1'b0;
    frame(4'hc, 12'($urandom), 16);
    apb(1'b1, 8'h00, 32'h1);
    en = 1'b1;
    async_clear_n <= 1'b0;
    #1 check({20'h0, out_code_a}, 32'h0);
    {sa, sb, oa, ob} = 48'h0;
    frame(4'hc, 12'($urandom), 16);
    rd(8'h04, 32'h4);
    async_clear_n <= 1'b1;
    frame(4'h6, 12'($urandom), 16);
    chain_enable <= 1'b1;
    d1 = 12'($urandom);
    frame(4'h0, d1, 16);
    frame(4'h2, 12'($urandom), 16);
    check({16'h0, u_host.rx}, {16'h0, 4'h0, d1});
    rd(8'h04, 32'h8);
    chain_enable <= 1'b0;
    frame(4'he, 12'h0, 16);
    rd(8'h1c, 32'h18);
    results();
  end
endmodule
